// ---- inc/wdcks_if.sv ----
// Purpose: register link between processor-side master and watchdog
// Assumes: single clock, one request per pulse of req
// Notes: read data returns with rvalid one cycle after the request
`timescale 1ns/1ps
interface wdcks_if;
    logic req;
    logic write;
    logic sel;
    logic [1:0] size;
    logic [15:0] wdata;
    logic [7:0] rdata;
    logic rvalid;

    modport device (
        input req, write, sel, size, wdata,
        output rdata, rvalid
    );
    modport host (
        output req, write, sel, size, wdata,
        input rdata, rvalid
    );
endinterface

// ---- inc/wdcks_pkg.sv ----
// Purpose: shared constants and types for the keyed watchdog block
// Assumes: 16-bit word writes carry a key byte in the upper half
// Notes: control/status byte layout and size codes live here
package wdcks_pkg;
    // ==========================================================
    // register selection
    localparam logic SEL_COUNT = 1'b0;
    localparam logic SEL_CTRL = 1'b1;

    // ==========================================================
    // transfer size codes on the register link
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // ==========================================================
    // write keys held in the upper byte of a word write
    localparam logic [7:0] KEY_COUNT = 8'h5A;
    localparam logic [7:0] KEY_CTRL = 8'hA5;

    // ==========================================================
    // control/status field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_MODE = 6;
    localparam int BIT_RST_TYPE = 5;
    localparam int BIT_WATCHDOG_OVERFLOW_FLAG = 4;
    localparam int BIT_INTERVAL_OVERFLOW_FLAG = 3;
    localparam int CKS_MSB = 2;
    localparam int CKS_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic MODE_WATCHDOG = 1'b1;

    // ==========================================================
    // prescaler: largest divide ratio is 4096
    localparam int PRESC_WIDTH = 12;
    localparam logic [PRESC_WIDTH-1:0] PRESC_ZERO = 12'h000;
    localparam logic [PRESC_WIDTH-1:0] PRESC_ONE = 12'h001;

    // divide ratio minus one, used as a terminal mask
    function automatic logic [PRESC_WIDTH-1:0] wdcks_div_mask(
        input logic [2:0] cks);
        logic [PRESC_WIDTH-1:0] m;
        m = 12'h000;
        case (cks)
            3'h0: m = 12'h000;
            3'h1: m = 12'h003;
            3'h2: m = 12'h00F;
            3'h3: m = 12'h01F;
            3'h4: m = 12'h03F;
            3'h5: m = 12'h0FF;
            3'h6: m = 12'h3FF;
            3'h7: m = 12'hFFF;
            default: m = 12'h000;
        endcase
        return m;
    endfunction
endpackage

// ---- verif/wdcks_assertions.sv ----
// Purpose: link checks between host and watchdog ends
// Assumes: one clock, synchronous active-high reset
// Notes: sees the interface signals only
`timescale 1ns/1ps
module wdcks_assertions
    import wdcks_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic req,
    input wire logic write,
    input wire logic sel,
    input wire logic [1:0] size,
    input wire logic [15:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // ==========================================================
    // request and answer timing
    a_read_answer: assert property (req && !write |=> rvalid)
        else $error("read got no answer next cycle");
    a_valid_cause: assert property (rvalid |-> $past(req && !write))
        else $error("answer without a read");
    a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
        else $error("read data moved without answer");
    a_req_pulse: assert property (req |=> !req)
        else $error("request longer than one cycle");
    a_read_gap: assert property (req && !write |=> !req [*2])
        else $error("read requests too close");
    a_size_legal: assert property (req |-> size != 2'h3)
        else $error("unknown transfer size");
    // ==========================================================
    // key bytes on word writes
    a_count_key: assert property (req && write && size == SIZE_WORD
        && sel == SEL_COUNT |-> wdata[15:8] == KEY_COUNT)
        else $error("counter write without its key");
    a_ctrl_key: assert property (req && write && size == SIZE_WORD
        && sel == SEL_CTRL |-> wdata[15:8] == KEY_CTRL)
        else $error("control write without its key");
endmodule

// ---- verif/wdcks_tb.sv ----
// Purpose: host and device back to back, plus a raw-driven device
// Assumes: host inserts keys; second link breaks keys and sizes
// Notes: ce held high on both devices
`timescale 1ns/1ps
module wdcks_tb
    import wdcks_pkg::*;
;
    logic i_clk, i_reset, start, wr, sel, busy, rdv;
    logic irq, wrst, rtype, rtype2;
    logic [1:0] size;
    logic [7:0] data, rdd, cnt, cnt2, v;
    int err_total, cmp_count, cyc, n;
    int divs[8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
    wdcks_if link();
    wdcks_if link2();
    wdcks_device wdcks_device_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(1'b1), .bus(link), .o_interval_irq(irq),
        .o_wdt_reset(wrst), .o_reset_type(rtype), .o_count(cnt));
    wdcks_device wdcks_device_i2 (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(1'b1), .bus(link2), .o_interval_irq(),
        .o_wdt_reset(), .o_reset_type(rtype2), .o_count(cnt2));
    wdcks_host wdcks_host_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(1'b1), .i_start(start), .i_write(wr), .i_sel(sel),
        .i_size(size), .i_data(data), .o_busy(busy), .o_rd_data(rdd),
        .o_rd_valid(rdv), .bus(link));
    wdcks_assertions wdcks_assertions_i (.i_clk(i_clk),
        .i_reset(i_reset), .req(link.req), .write(link.write),
        .sel(link.sel), .size(link.size), .wdata(link.wdata),
        .rdata(link.rdata), .rvalid(link.rvalid));
    // ==========================================================
    // clock and hang guard
    initial begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            summarize();
        end
    end
    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmd(input logic w, s, input logic [1:0] z,
                       input logic [7:0] d);
        @(posedge i_clk) #1;
        start = 1;
        wr = w;
        sel = s;
        size = z;
        data = d;
        @(posedge i_clk) #1;
        start = 0;
        n = 0;
        while (busy !== 1'b0 && n < 50) begin
            @(posedge i_clk) #1;
            n++;
        end
        check("read valid", rdv, !w);
    endtask
    // raw word on the second link; data inverted once released
    task automatic raw(input logic s, input logic [1:0] z,
                       input logic [15:0] d);
        link2.req = 1;
        link2.sel = s;
        link2.size = z;
        link2.wdata = d;
        @(posedge i_clk) #1;
        link2.req = 0;
        link2.wdata = ~d;
        @(posedge i_clk) #1;
    endtask
    // cycles between two count steps at select c
    task automatic period(input logic [2:0] c, input int div);
        cmd(1, SEL_CTRL, SIZE_WORD, {5'h00, c});
        cmd(1, SEL_COUNT, SIZE_WORD, 8'h00);
        cmd(1, SEL_CTRL, SIZE_WORD, {5'h10, c});
        for (int p = 0; p < 2; p++) begin
            v = cnt;
            n = 0;
            while (cnt === v && n < 9000) begin
                @(posedge i_clk) #1;
                n++;
            end
        end
        check("divide", 16'(n), 16'(div));
        cmd(1, SEL_CTRL, SIZE_WORD, {5'h00, c});
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {start, wr, sel, size, data} = '0;
        {link2.req, link2.write, link2.sel, link2.size} = 5'h08;
        link2.wdata = 16'h0000;
        i_reset = 1;
        repeat (6) @(posedge i_clk);
        #1 i_reset = 0;
        cmd(0, SEL_CTRL, SIZE_WORD, 8'h00);
        check("ctrl reset", rdd, CTRL_RESET);
        cmd(1, SEL_COUNT, SIZE_WORD, 8'h37);
        check("count load", cnt, 8'h37);
        cmd(0, SEL_COUNT, SIZE_WORD, 8'h00);
        check("count read", rdd, 8'h37);
        cmd(1, SEL_COUNT, SIZE_BYTE, 8'h11);
        cmd(1, SEL_COUNT, SIZE_LONG, 8'h22);
        check("count size", cnt, 8'h37);
        cmd(1, SEL_CTRL, SIZE_WORD, 8'h65);
        cmd(1, SEL_CTRL, SIZE_BYTE, 8'h27);
        cmd(0, SEL_CTRL, SIZE_WORD, 8'h00);
        check("ctrl load", rdd, 8'h65);
        for (int i = 0; i < 8; i++) period(3'(i), divs[i]);
        v = cnt;
        repeat (20) @(posedge i_clk);
        check("stopped", cnt, v);
        // interval overflow from FE
        cmd(1, SEL_COUNT, SIZE_WORD, 8'hFE);
        cmd(1, SEL_CTRL, SIZE_WORD, 8'h80);
        repeat (4) @(posedge i_clk);
        check("irq", irq, 1'b1);
        cmd(0, SEL_CTRL, SIZE_WORD, 8'h00);
        check("interval_overflow_flag", rdd, 8'h88);
        // watchdog overflow from FE
        cmd(1, SEL_CTRL, SIZE_WORD, 8'h20);
        cmd(1, SEL_COUNT, SIZE_WORD, 8'hFE);
        cmd(1, SEL_CTRL, SIZE_WORD, 8'hE0);
        n = 0;
        while (wrst !== 1'b1 && n < 20) begin
            @(posedge i_clk) #1;
            n++;
        end
        check("wdt reset", {wrst, rtype}, 2'h3);
        cmd(0, SEL_CTRL, SIZE_WORD, 8'h00);
        check("watchdog_overflow_flag only", {irq, rdd}, 9'h0F0);
        // mid-run reset while the watchdog is counting
        i_reset = 1;
        repeat (2) @(posedge i_clk) #1;
        i_reset = 0;
        v = cnt;
        repeat (3) @(posedge i_clk) #1;
        check("reset stop", {cnt, v}, 16'h0000);
        check("reset flags", {wrst, rtype}, 2'h0);
        // broken keys and sizes on the second link
        raw(SEL_COUNT, SIZE_WORD, {KEY_CTRL, 8'h44});
        check("bad key", cnt2, 8'h00);
        raw(SEL_COUNT, SIZE_BYTE, {KEY_COUNT, 8'h44});
        raw(SEL_COUNT, SIZE_LONG, {KEY_COUNT, 8'h44});
        check("bad size", cnt2, 8'h00);
        raw(SEL_COUNT, SIZE_WORD, {KEY_COUNT, 8'h44});
        check("good key", cnt2, 8'h44);
        raw(SEL_CTRL, SIZE_WORD, {KEY_COUNT, 8'h20});
        check("ctrl bad key", rtype2, 1'b0);
        raw(SEL_CTRL, SIZE_WORD, {KEY_CTRL, 8'h20});
        check("ctrl key", rtype2, 1'b1);
        summarize();
    end
endmodule

// ---- verilog/wdcks_device.sv ----
// Purpose: watchdog/interval timer with divided count clock and keyed
//          word-only write protection of counter and control/status
// Assumes: link inputs synchronous to i_clk; i_ce gates all state
// Notes: overflow flags are cleared by a keyed write of 0; a
//        simultaneous overflow keeps the flag set
`timescale 1ns/1ps

module wdcks_device
    import wdcks_pkg::*;
#(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    wdcks_if.device bus,
    output logic o_interval_irq,
    output logic o_wdt_reset,
    output logic o_reset_type,
    output logic [7:0] o_count
);

    // ==========================================================
    // elaboration check
    generate
        if (COUNT_WIDTH != 8) begin : g_bad_width
            $error("wdcks_device supports an 8-bit counter only");
        end
    endgenerate

    // ==========================================================
    // state
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [PRESC_WIDTH-1:0] presc;
    logic [PRESC_WIDTH-1:0] next_presc;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic wdt_reset;
    logic next_wdt_reset;

    // decoded controls
    logic enable;
    logic mode_wdt;
    logic [2:0] cks;
    logic tick;
    logic overflow;
    logic word_wr;
    logic count_wr;
    logic ctrl_wr;

    assign enable = ctrl[BIT_ENABLE];
    assign mode_wdt = (ctrl[BIT_MODE] == MODE_WATCHDOG);
    assign cks = ctrl[CKS_MSB:CKS_LSB];

    // ==========================================================
    // keyed write decode
    // byte and long writes never qualify
    assign word_wr = bus.req && bus.write && (bus.size == SIZE_WORD);
    // the upper byte must match the target's own key
    assign count_wr = word_wr && (bus.sel == SEL_COUNT)
        && (bus.wdata[15:8] == KEY_COUNT);
    assign ctrl_wr = word_wr && (bus.sel == SEL_CTRL)
        && (bus.wdata[15:8] == KEY_CTRL);

    // ==========================================================
    // count clock: one tick per division period while enabled
    // the prescaler is not protected against a select change while
    // running; software keeps the select steady during counting
    assign tick = enable
        && ((presc & wdcks_div_mask(cks)) == wdcks_div_mask(cks));
    assign overflow = tick && (count == COUNT_MAX);

    always_comb begin
        next_presc = presc;
        if (!enable) begin
            next_presc = PRESC_ZERO;
        end else begin
            next_presc = presc + PRESC_ONE;
        end
    end

    // ==========================================================
    // counter: a keyed write wins over a tick in the same cycle
    always_comb begin
        next_count = count;
        if (count_wr) begin
            next_count = bus.wdata[7:0];
        end else if (tick) begin
            next_count = count + 8'h01; // wraps and keeps counting
        end
    end

    // ==========================================================
    // control/status: keyed write, then overflow flags set on top
    always_comb begin
        next_ctrl = ctrl;
        next_wdt_reset = 1'b0;
        if (ctrl_wr) begin
            next_ctrl = bus.wdata[7:0];
        end
        if (overflow) begin
            if (mode_wdt) begin
                next_ctrl[BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1; // set beats clear
                next_wdt_reset = 1'b1;
            end else begin
                next_ctrl[BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1; // set beats clear
            end
        end
        // no watchdog-mode path touches the interval flag
    end

    // ==========================================================
    // read port: any size reads the addressed byte
    always_comb begin
        next_rvalid = bus.req && !bus.write;
        next_rdata = rdata;
        if (bus.req && !bus.write) begin
            next_rdata = (bus.sel == SEL_CTRL) ? ctrl : count;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count <= COUNT_RESET;
            ctrl <= CTRL_RESET;
            presc <= PRESC_ZERO;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            wdt_reset <= 1'b0;
        end else if (i_ce) begin
            count <= next_count;
            ctrl <= next_ctrl;
            presc <= next_presc;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            wdt_reset <= next_wdt_reset;
        end
    end

    // ==========================================================
    // outputs
    assign bus.rdata = rdata;
    assign bus.rvalid = rvalid;
    // interrupt request stands while the flag is set in interval mode
    assign o_interval_irq = ctrl[BIT_INTERVAL_OVERFLOW_FLAG] && !mode_wdt;
    assign o_wdt_reset = wdt_reset;
    assign o_reset_type = ctrl[BIT_RST_TYPE];
    assign o_count = count;
endmodule

// ---- verilog/wdcks_host.sv ----
// Purpose: processor-side master that issues keyed register transfers
// Assumes: one command at a time, i_start taken only when not busy
// Notes: i_size lets a caller issue byte or long writes on purpose
`timescale 1ns/1ps
module wdcks_host
    import wdcks_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic i_sel,
    input wire logic [1:0] i_size,
    input wire logic [7:0] i_data,
    output logic o_busy,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    wdcks_if.host bus
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10
    } wdcks_host_state_type;

    wdcks_host_state_type state;
    wdcks_host_state_type next_state;
    logic write;
    logic next_write;
    logic sel;
    logic next_sel;
    logic [1:0] size;
    logic [1:0] next_size;
    logic [15:0] wdata;
    logic [15:0] next_wdata;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic rd_valid;
    logic next_rd_valid;

    // ==========================================================
    // command sequencing; the key goes in the upper byte
    always_comb begin
        next_state = state;
        next_write = write;
        next_sel = sel;
        next_size = size;
        next_wdata = wdata;
        next_rd_data = rd_data;
        next_rd_valid = 1'b0;
        case (state)
            ST_IDLE: begin
                if (i_start) begin
                    next_write = i_write;
                    next_sel = i_sel;
                    next_size = i_size;
                    next_wdata = {(i_sel == SEL_CTRL) ? KEY_CTRL : KEY_COUNT,
                        i_data};
                    next_state = ST_REQ;
                end
            end
            ST_REQ: begin
                next_state = write ? ST_IDLE : ST_WAIT;
            end
            ST_WAIT: begin
                if (bus.rvalid) begin
                    next_rd_data = bus.rdata;
                    next_rd_valid = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
            write <= 1'b0;
            sel <= SEL_COUNT;
            size <= SIZE_WORD;
            wdata <= 16'h0000;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            write <= next_write;
            sel <= next_sel;
            size <= next_size;
            wdata <= next_wdata;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // ==========================================================
    // outputs
    assign bus.req = (state == ST_REQ) && i_ce;
    assign bus.write = write;
    assign bus.sel = sel;
    assign bus.size = size;
    assign bus.wdata = wdata;
    assign o_busy = (state != ST_IDLE);
    assign o_rd_data = rd_data;
    assign o_rd_valid = rd_valid;
endmodule
